// ===== rtl/txlb_backend.v
// Transmit back end: overrides, frame slip, clock source and buffer, encoder, jitter attenuator.
// Assumes all link-side inputs are pins sampled on clk; bit rates arrive as enable pins.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "txlb_map.vh"
module txlb_backend #(
  parameter BUF_DEPTH = 16,
  parameter BUF_AW    = 4,
  parameter JA_DEPTH  = 128
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Register port
  input  wire [9:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdData,
  // Stream and clock enables
  input  wire       txDataIn,
  input  wire       bpTick,
  input  wire       recTick,
  input  wire       mstTick,
  input  wire       receiveSignalLoss,
  // Line side
  output reg        linePos,
  output reg        lineNeg,
  output reg        lineStrobe,
  output reg  [1:0] txClockSource,
  output reg        bufferInUse,
  output reg        bufferSlip,
  output wire       irq
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg [4:0] syncA_reg;
  reg [4:0] syncB_reg;
  wire      dIn;
  wire      bpT;
  wire      recT;
  wire      mstT;
  wire      sigLoss;
  always @(posedge clk)
  begin
    syncA_reg <= {receiveSignalLoss, mstTick, recTick, bpTick, txDataIn};
    syncB_reg <= syncA_reg;
  end
  assign dIn  = syncB_reg[0];
  assign bpT  = syncB_reg[1];
  assign recT = syncB_reg[2];
  assign mstT = syncB_reg[3];
  assign sigLoss = syncB_reg[4];
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] jaCfg_reg;
  reg [7:0] txCfg0_reg;
  reg [7:0] maint1_reg;
  reg [7:0] maint2_reg;
  reg [7:0] irqEn_reg;
  reg [7:0] fgen_reg;
  reg [7:0] timing_reg;
  reg [7:0] mode_reg;
  reg [6:0] gap_reg;
  reg       faultFlag_reg;
  wire      jaFault;
  wire [7:0] jaFill;
  wire      clearFault;
  assign clearFault = regWr && (regAddr == `TXLB_ADDR_IRQ_ST1) && regWrData[`TXLB_IRQ_JA_FAULT];
  always @(posedge clk)
  begin
    if (rst)
    begin
      jaCfg_reg  <= 8'h00;
      txCfg0_reg <= 8'h00;
      maint1_reg <= 8'h00;
      maint2_reg <= 8'h00;
      irqEn_reg  <= 8'h00;
      fgen_reg   <= 8'h00;
      timing_reg <= 8'h00;
      mode_reg   <= 8'h00;
    end
    else if (regWr)
    begin
      if (regAddr == `TXLB_ADDR_JA_CFG)
        jaCfg_reg <= regWrData;
      else if (regAddr == `TXLB_ADDR_TX_CFG0)
        txCfg0_reg <= regWrData;
      else if (regAddr == `TXLB_ADDR_MAINT1)
        maint1_reg <= regWrData;
      else if (regAddr == `TXLB_ADDR_MAINT2)
        maint2_reg <= regWrData;
      else if (regAddr == `TXLB_ADDR_IRQ_EN1)
        irqEn_reg <= regWrData;
      else if (regAddr == `TXLB_ADDR_FGEN1)
        fgen_reg <= regWrData;
      else if (regAddr == `TXLB_ADDR_TIMING)
        timing_reg <= regWrData;
      else if (regAddr == `TXLB_ADDR_MODE)
        mode_reg <= regWrData;
    end
  end
  // Fault flag: set wins over a write-one clear.
  always @(posedge clk)
  begin
    if (rst)
      faultFlag_reg <= 1'b0;
    else if (jaFault)
      faultFlag_reg <= 1'b1;
    else if (clearFault)
      faultFlag_reg <= 1'b0;
  end
  assign irq = faultFlag_reg && irqEn_reg[`TXLB_IRQ_JA_FAULT];
  always @(posedge clk)
  begin
    if (rst)
      regRdData <= 8'h00;
    else if (!regRd)
      regRdData <= 8'h00;
    else if (regAddr == `TXLB_ADDR_JA_CFG)
      regRdData <= jaCfg_reg;
    else if (regAddr == `TXLB_ADDR_TX_CFG0)
      regRdData <= txCfg0_reg;
    else if (regAddr == `TXLB_ADDR_MAINT1)
      regRdData <= maint1_reg;
    else if (regAddr == `TXLB_ADDR_MAINT2)
      regRdData <= maint2_reg;
    else if (regAddr == `TXLB_ADDR_IRQ_EN1)
      regRdData <= irqEn_reg;
    else if (regAddr == `TXLB_ADDR_GAP)
      regRdData <= {1'b0, gap_reg};
    else if (regAddr == `TXLB_ADDR_IRQ_ST1)
      regRdData <= {7'h00, faultFlag_reg};
    else if (regAddr == `TXLB_ADDR_FGEN1)
      regRdData <= fgen_reg;
    else if (regAddr == `TXLB_ADDR_TIMING)
      regRdData <= timing_reg;
    else if (regAddr == `TXLB_ADDR_MODE)
      regRdData <= mode_reg;
    else
      regRdData <= 8'h00;
  end
  // ****************************************************************
  // Clock source and transmit buffer selection
  // ****************************************************************
  wire isE1;
  wire isMaster;
  wire e1RateSlave;
  wire timSel;
  reg  useBuf;
  reg  [1:0] srcSel;
  reg  lineTick;
  assign isE1        = mode_reg[`TXLB_MD_E1];
  assign isMaster    = mode_reg[`TXLB_MD_MASTER] && !mode_reg[`TXLB_MD_MUX];
  assign e1RateSlave = !isMaster && !isE1 && mode_reg[`TXLB_MD_E1RATE_BP];
  assign timSel      = timing_reg[`TXLB_TM_SELECT];
  always @*
  begin
    if (isMaster)
    begin
      useBuf = 1'b0;
      srcSel = timSel ? `TXLB_SRC_MASTER : `TXLB_SRC_LINE;
    end
    else if (e1RateSlave)
    begin
      useBuf = 1'b1;
      srcSel = `TXLB_SRC_MASTER;
    end
    else if (timSel)
    begin
      useBuf = 1'b1;
      srcSel = `TXLB_SRC_MASTER;
    end
    else
    begin
      useBuf = 1'b0;
      srcSel = `TXLB_SRC_BACKPLANE;
    end
    if (srcSel == `TXLB_SRC_LINE)
      lineTick = recT;
    else if (srcSel == `TXLB_SRC_MASTER)
      lineTick = mstT;
    else
      lineTick = bpT;
  end
  // Elastic buffer; an empty read repeats, a full write drops (controlled slip).
  reg              bufMem [0:BUF_DEPTH-1];
  reg [BUF_AW:0]   bufWr_reg;
  reg [BUF_AW:0]   bufRd_reg;
  reg              bufOut_reg;
  wire [BUF_AW:0]  bufFill;
  assign bufFill = bufWr_reg - bufRd_reg;
  always @(posedge clk)
  begin
    if (rst || !useBuf)
    begin
      bufWr_reg  <= {(BUF_AW+1){1'b0}};
      bufRd_reg  <= {(BUF_AW+1){1'b0}};
      bufOut_reg <= 1'b0;
      bufferSlip <= 1'b0;
    end
    else
    begin
      bufferSlip <= 1'b0;
      if (bpT)
      begin
        if (bufFill == BUF_DEPTH[BUF_AW:0])
          bufferSlip <= 1'b1;
        else
        begin
          bufMem[bufWr_reg[BUF_AW-1:0]] <= dIn;
          bufWr_reg <= bufWr_reg + {{BUF_AW{1'b0}}, 1'b1};
        end
      end
      if (lineTick)
      begin
        if (bufFill == {(BUF_AW+1){1'b0}})
          bufferSlip <= 1'b1;
        else
        begin
          bufOut_reg <= bufMem[bufRd_reg[BUF_AW-1:0]];
          bufRd_reg  <= bufRd_reg + {{BUF_AW{1'b0}}, 1'b1};
        end
      end
    end
  end
  // ****************************************************************
  // Frame shift, overrides and line encoder
  // ****************************************************************
  reg  shiftPrev_reg;
  reg  slipPending_reg;
  reg  vioPrev_reg;
  reg  vioPending_reg;
  reg  srcBit_reg;
  reg  ovBit;
  reg  lastPulsePol_reg;
  reg  oddMarks_reg;
  reg  [3:0] zeroHist_reg;
  reg  [7:0] shiftPos_reg;
  reg  [7:0] shiftNeg_reg;
  wire shiftBit;
  wire vioBit;
  assign shiftBit = fgen_reg[`TXLB_FG_SHIFT];
  assign vioBit   = maint2_reg[`TXLB_M2_VIOLATION];
  always @*
  begin
    ovBit = useBuf ? bufOut_reg : srcBit_reg;
    if (fgen_reg[`TXLB_FG_ZEROS])
      ovBit = 1'b0;
    else if (fgen_reg[`TXLB_FG_ONES] || (maint1_reg[`TXLB_M1_AUTO_ONES] && sigLoss))
      ovBit = 1'b1;
  end
  always @(posedge clk)
  begin
    if (rst)
    begin
      shiftPrev_reg    <= 1'b0;
      slipPending_reg  <= 1'b0;
      vioPrev_reg      <= 1'b0;
      vioPending_reg   <= 1'b0;
      srcBit_reg       <= 1'b0;
      lastPulsePol_reg <= 1'b0;
      oddMarks_reg     <= 1'b0;
      zeroHist_reg     <= 4'h0;
      shiftPos_reg     <= 8'h00;
      shiftNeg_reg     <= 8'h00;
    end
    else
    begin
      shiftPrev_reg <= shiftBit;
      vioPrev_reg   <= vioBit;
      if (lineTick)
      begin
        // A pending slip repeats the held bit once.
        if (slipPending_reg)
          slipPending_reg <= 1'b0;
        else
          srcBit_reg <= dIn;
        if (ovBit && vioPending_reg)
        begin
          shiftPos_reg   <= {lastPulsePol_reg, shiftPos_reg[7:1]};
          shiftNeg_reg   <= {!lastPulsePol_reg, shiftNeg_reg[7:1]};
          zeroHist_reg   <= 4'h0;
          vioPending_reg <= 1'b0;
        end
        else if (ovBit)
        begin
          shiftPos_reg     <= {!lastPulsePol_reg, shiftPos_reg[7:1]};
          shiftNeg_reg     <= {lastPulsePol_reg, shiftNeg_reg[7:1]};
          lastPulsePol_reg <= !lastPulsePol_reg;
          oddMarks_reg     <= !oddMarks_reg;
          zeroHist_reg     <= 4'h0;
        end
        else if (txCfg0_reg[`TXLB_CFG0_LINECODE] && !isE1 && zeroHist_reg == 4'h7)
        begin
          // B8ZS: 000VB0VB over the eight zeros.
          shiftPos_reg <= {lastPulsePol_reg, !lastPulsePol_reg, 1'b0, !lastPulsePol_reg, lastPulsePol_reg,
                           shiftPos_reg[3:1]};
          shiftNeg_reg <= {!lastPulsePol_reg, lastPulsePol_reg, 1'b0, lastPulsePol_reg, !lastPulsePol_reg,
                           shiftNeg_reg[3:1]};
          zeroHist_reg <= 4'h0;
        end
        else if (txCfg0_reg[`TXLB_CFG0_LINECODE] && isE1 && zeroHist_reg == 4'h3)
        begin
          // HDB3: 000V or B00V, balanced by marks since last substitution.
          shiftPos_reg <= {!oddMarks_reg ? !lastPulsePol_reg : lastPulsePol_reg,
                           shiftPos_reg[7:6], (!oddMarks_reg && !lastPulsePol_reg), shiftPos_reg[4:1]};
          shiftNeg_reg <= {!oddMarks_reg ? lastPulsePol_reg : !lastPulsePol_reg,
                           shiftNeg_reg[7:6], (!oddMarks_reg && lastPulsePol_reg), shiftNeg_reg[4:1]};
          lastPulsePol_reg <= !oddMarks_reg ? !lastPulsePol_reg : lastPulsePol_reg;
          oddMarks_reg <= 1'b0;
          zeroHist_reg <= 4'h0;
        end
        else
        begin
          shiftPos_reg <= {1'b0, shiftPos_reg[7:1]};
          shiftNeg_reg <= {1'b0, shiftNeg_reg[7:1]};
          zeroHist_reg <= zeroHist_reg + 4'h1;
        end
      end
      if (shiftBit != shiftPrev_reg)
        slipPending_reg <= 1'b1;
      if (vioBit && !vioPrev_reg)
        vioPending_reg <= 1'b1;
    end
  end
  // ****************************************************************
  // Jitter attenuator and line output
  // ****************************************************************
  wire        jaEnable;
  wire [1:0]  jaBit;
  wire [1:0]  jaValid;
  wire [1:0]  jaFaultV;
  wire [15:0] jaFillV;
  genvar      rail;
  assign jaEnable = jaCfg_reg[`TXLB_JA_ENABLE];
  assign jaFault  = |jaFaultV;
  assign jaFill   = jaFillV[7:0];
  generate
    for (rail = 0; rail < 2; rail = rail + 1)
    begin : gRail
      txlb_jitter_fifo #(
        .MAX_DEPTH (JA_DEPTH),
        .PTR_W     (8)
      ) uJitter (
        .clk       (clk),
        .rst       (rst),
        .depthSel  (jaCfg_reg[`TXLB_JA_DEPTH_HI:`TXLB_JA_DEPTH_LO]),
        .cornerSel (jaCfg_reg[`TXLB_JA_CORNER]),
        .limitEn   (jaCfg_reg[`TXLB_POINTER_LIMIT_FUNCTION]),
        .bypass    (!jaEnable),
        .wrEn      (lineTick),
        .wrBit     ((rail == 0) ? shiftPos_reg[0] : shiftNeg_reg[0]),
        .rdBit     (jaBit[rail]),
        .rdValid   (jaValid[rail]),
        .fill      (jaFillV[rail*8 +: 8]),
        .fault     (jaFaultV[rail])
      );
    end
  endgenerate
  always @(posedge clk)
  begin
    if (rst)
    begin
      linePos       <= 1'b0;
      lineNeg       <= 1'b0;
      lineStrobe    <= 1'b0;
      txClockSource <= `TXLB_SRC_LINE;
      bufferInUse   <= 1'b0;
      gap_reg       <= 7'h00;
    end
    else
    begin
      txClockSource <= srcSel;
      bufferInUse   <= useBuf;
      // Both rails pass through twin attenuator FIFOs that run in lock step.
      lineStrobe <= jaEnable ? &jaValid : lineTick;
      if (jaEnable ? &jaValid : lineTick)
      begin
        linePos <= jaEnable ? jaBit[0] : shiftPos_reg[0];
        lineNeg <= jaEnable ? jaBit[1] : shiftNeg_reg[0];
      end
      if (!jaCfg_reg[`TXLB_JA_PEAK])
        gap_reg <= jaFill[6:0];
      else if (jaFill[6:0] > gap_reg)
        gap_reg <= jaFill[6:0];
    end
  end
endmodule // txlb_backend

// ===== rtl/txlb_map.vh
// Register offsets, field positions and fixed figures of the transmit line back end.
// Included by every design file of the block; holds definitions only.
`ifndef TXLB_MAP_VH
`define TXLB_MAP_VH
// ****************************************************************
// Register offsets
// ****************************************************************
`define TXLB_ADDR_JA_CFG     10'h021
`define TXLB_ADDR_TX_CFG0    10'h022
`define TXLB_ADDR_MAINT1     10'h02C
`define TXLB_ADDR_MAINT2     10'h031
`define TXLB_ADDR_IRQ_EN1    10'h034
`define TXLB_ADDR_GAP        10'h038
`define TXLB_ADDR_IRQ_ST1    10'h03B
`define TXLB_ADDR_FGEN1      10'h06C
`define TXLB_ADDR_TIMING     10'h070
`define TXLB_ADDR_MODE       10'h0F0
// ****************************************************************
// Field positions
// ****************************************************************
`define TXLB_JA_ENABLE       0
`define TXLB_JA_DEPTH_LO     1
`define TXLB_JA_DEPTH_HI     2
`define TXLB_JA_CORNER       3
`define TXLB_POINTER_LIMIT_FUNCTION        4
`define TXLB_JA_PEAK         5
`define TXLB_CFG0_LINECODE   0
`define TXLB_M1_AUTO_ONES    0
`define TXLB_M2_VIOLATION    0
`define TXLB_IRQ_JA_FAULT    0
`define TXLB_FG_ONES         0
`define TXLB_FG_ZEROS        1
`define TXLB_FG_SHIFT        2
`define TXLB_TM_SELECT       0
`define TXLB_MD_E1           0
`define TXLB_MD_MASTER       1
`define TXLB_MD_MUX          2
`define TXLB_MD_E1RATE_BP    3
// ****************************************************************
// Jitter depth codes, clock sources and fixed figures
// ****************************************************************
`define TXLB_DEPTH_32        2'h0
`define TXLB_DEPTH_64        2'h1
`define TXLB_DEPTH_128       2'h2
`define TXLB_SRC_LINE        2'h0
`define TXLB_SRC_MASTER      2'h1
`define TXLB_SRC_BACKPLANE   2'h2
`define TXLB_LIMIT_MARGIN    8'h04
`define TXLB_CORNER_T1_WIDE  5.0
`define TXLB_CORNER_T1_NARR  1.26
`define TXLB_CORNER_E1_WIDE  6.77
`define TXLB_CORNER_E1_NARR  0.87
`define TXLB_DPLL_SHIFT_W    4'h6
`define TXLB_DPLL_SHIFT_N    4'h8
`endif

// ===== rtl/txlb_jitter_fifo.v
// Jitter attenuator bit FIFO with selectable depth and a phase-accumulator read clock.
// Assumes write enables arrive as one-cycle pulses on clk; reads are timed inside.
`timescale 1ns/1ns
`include "txlb_map.vh"
module txlb_jitter_fifo #(
  parameter MAX_DEPTH = 128,
  parameter PTR_W     = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Control
  input  wire [1:0]       depthSel,
  input  wire             cornerSel,
  input  wire             limitEn,
  input  wire             bypass,
  // Data in
  input  wire             wrEn,
  input  wire             wrBit,
  // Data out
  output reg              rdBit,
  output reg              rdValid,
  output wire [PTR_W-1:0] fill,
  output reg              fault
);
  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  reg              mem [0:MAX_DEPTH-1];
  reg [PTR_W-1:0]  wrPtr_reg;
  reg [PTR_W-1:0]  rdPtr_reg;
  reg [15:0]       phase_reg;
  reg [15:0]       step_reg;
  reg              started_reg;
  wire [PTR_W-1:0] depth;
  wire [PTR_W-1:0] half;
  wire             near;
  wire             far;
  wire             rdTick;
  wire [16:0]      phaseSum;
  assign depth = (depthSel == `TXLB_DEPTH_32) ? 8'h20 : (depthSel == `TXLB_DEPTH_64) ? 8'h40 : 8'h80;
  assign half  = {1'b0, depth[PTR_W-1:1]};
  assign fill  = wrPtr_reg - rdPtr_reg;
  assign near  = limitEn && (fill <= `TXLB_LIMIT_MARGIN);
  assign far   = limitEn && (fill >= depth - `TXLB_LIMIT_MARGIN);
  assign phaseSum = {1'b0, phase_reg} + {1'b0, step_reg};
  assign rdTick = started_reg && phaseSum[16] && !near;
  // ****************************************************************
  // Write side, DPLL read clock and fault detection
  // ****************************************************************
  always @(posedge clk)
  begin
    if (rst || bypass)
    begin
      wrPtr_reg   <= 8'h00;
      rdPtr_reg   <= 8'h00;
      phase_reg   <= 16'h0000;
      step_reg    <= 16'h8000;
      started_reg <= 1'b0;
      rdBit       <= 1'b0;
      rdValid     <= 1'b0;
      fault       <= 1'b0;
    end
    else
    begin
      fault   <= 1'b0;
      rdValid <= 1'b0;
      if (wrEn)
      begin
        mem[wrPtr_reg[6:0]] <= wrBit;
        if (fill >= depth)
          fault <= 1'b1;
        else
          wrPtr_reg <= wrPtr_reg + 8'h01;
        if (fill >= half)
          started_reg <= 1'b1;
        // DPLL tracks write rate; corner sets loop gain.
        if (fill > half)
          step_reg <= step_reg + (16'h0001 << (cornerSel ? `TXLB_DPLL_SHIFT_N : `TXLB_DPLL_SHIFT_W));
        else if (fill < half)
          step_reg <= step_reg - (16'h0001 << (cornerSel ? `TXLB_DPLL_SHIFT_N : `TXLB_DPLL_SHIFT_W));
      end
      phase_reg <= far ? 16'hFFFF : phaseSum[15:0];
      if (rdTick || (far && started_reg))
      begin
        if (fill == 8'h00)
          fault <= 1'b1;
        else
        begin
          rdBit     <= mem[rdPtr_reg[6:0]];
          rdValid   <= 1'b1;
          rdPtr_reg <= rdPtr_reg + 8'h01;
        end
      end
    end
  end
endmodule // txlb_jitter_fifo

// ===== testbench/txlb_backend_properties.sv
// Port-level assertions for the transmit back end.
// Assumes binding to txlb_backend and register writes over the plain port.
`timescale 1ns/1ns
`include "txlb_map.vh"
module txlb_backend_properties (
  input wire       clk,
  input wire       rst,
  input wire [9:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWr,
  input wire       regRd,
  input wire [7:0] regRdData,
  input wire       linePos,
  input wire       lineNeg,
  input wire       lineStrobe,
  input wire [1:0] txClockSource,
  input wire       bufferInUse,
  input wire       bufferSlip,
  input wire       irq
);
  // ****************************************************************
  // Shadows of the mode, timing and enable registers
  // ****************************************************************
  reg  [3:0] modeSh;
  reg        tselSh;
  reg        ieSh;
  reg  [1:0] settle;
  wire       wMode = regWr && (regAddr == `TXLB_ADDR_MODE);
  wire       wTim  = regWr && (regAddr == `TXLB_ADDR_TIMING);
  wire       slave = !modeSh[`TXLB_MD_MASTER] || modeSh[`TXLB_MD_MUX];
  wire       e1bp  = slave && modeSh[`TXLB_MD_E1RATE_BP] && !modeSh[`TXLB_MD_E1];
  wire       ok    = (settle == 2'h3);
  always @(posedge clk)
  begin
    if (rst)
    begin
      modeSh <= 4'h0;
      tselSh <= 1'b0;
      ieSh   <= 1'b0;
      settle <= 2'h0;
    end
    else
    begin
      if (wMode)
        modeSh <= regWrData[3:0];
      if (wTim)
        tselSh <= regWrData[0];
      if (regWr && (regAddr == `TXLB_ADDR_IRQ_EN1))
        ieSh <= regWrData[0];
      if (wMode || wTim)
        settle <= 2'h1;
      else if (settle != 2'h0 && settle != 2'h3)
        settle <= settle + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RD_IDLE: assert property (regRdData != 8'h00 |-> $past(regRd))
    else $error("read data outside the read answer cycle");
  AST_IRQ_OFF: assert property (regWr && regAddr == `TXLB_ADDR_IRQ_EN1 && !regWrData[0] |=> !irq)
    else $error("interrupt stays up after its enable is removed");
  AST_IRQ_EN: assert property (irq |-> ieSh)
    else $error("interrupt raised while disabled");
  AST_SLIP_BUF: assert property (bufferSlip |-> bufferInUse)
    else $error("slip reported with the buffer bypassed");
  AST_MASTER: assert property (ok && !slave |-> !bufferInUse)
    else $error("buffer in use in master mode");
  AST_E1BP: assert property (ok && e1bp |-> bufferInUse && txClockSource == `TXLB_SRC_MASTER)
    else $error("E1-rate backplane slave not buffered");
  AST_SEL1: assert property (ok && slave && !e1bp && tselSh |-> bufferInUse && txClockSource == `TXLB_SRC_MASTER)
    else $error("slave select one not buffered on master clock");
  AST_SEL0: assert property (ok && slave && !e1bp && !tselSh |-> !bufferInUse && txClockSource == `TXLB_SRC_BACKPLANE)
    else $error("slave select zero not on backplane clock");
  AST_RAIL: assert property (!(linePos && lineNeg))
    else $error("both line rails high");
  AST_RESET: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> !lineStrobe && !bufferSlip && txClockSource == 2'h0)
    else $error("outputs not cleared by reset");
endmodule // txlb_backend_properties
bind txlb_backend txlb_backend_properties txlb_backend_properties_i (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .linePos(linePos),
  .lineNeg(lineNeg), .lineStrobe(lineStrobe), .txClockSource(txClockSource), .bufferInUse(bufferInUse),
  .bufferSlip(bufferSlip), .irq(irq));

// ===== testbench/txlb_line_partner.sv
// Line side model: recovered and master ticks, tallies of line marks and violations.
// Assumes one dual-rail line bit per strobe.
`timescale 1ns/1ns
module txlb_line_partner (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Line bits
  input  wire        linePos,
  input  wire        lineNeg,
  input  wire        lineStrobe,
  // Ticks and tallies
  output reg         recTick,
  output reg         mstTick,
  output reg  [15:0] markCnt,
  output reg  [15:0] bpvCnt,
  output reg  [15:0] strobeCnt
);
  reg [2:0] ph;
  reg       lastNeg;
  always @(posedge clk)
  begin
    if (rst)
    begin
      ph        <= 3'h0;
      recTick   <= 1'b0;
      mstTick   <= 1'b0;
      markCnt   <= 16'h0000;
      bpvCnt    <= 16'h0000;
      strobeCnt <= 16'h0000;
      lastNeg   <= 1'b0;
    end
    else
    begin
      ph      <= ph + 3'h1;
      recTick <= (ph == 3'h3);
      mstTick <= (ph == 3'h5);
      if (lineStrobe)
        strobeCnt <= strobeCnt + 16'h0001;
      if (lineStrobe && (linePos || lineNeg))
      begin
        markCnt <= markCnt + 16'h0001;
        lastNeg <= lineNeg;
        if (markCnt != 16'h0000 && lineNeg == lastNeg)
          bpvCnt <= bpvCnt + 16'h0001;
      end
    end
  end
endmodule // txlb_line_partner

// ===== testbench/txlb_backend_tb.sv
// Testbench of the transmit back end: registers, clock source table, overrides and line codes.
// Assumes the line partner model and the port checker are compiled beside it.
`timescale 1ns/1ns
`include "txlb_map.vh"
module txlb_backend_tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [9:0]  regAddr = 10'h000;
  reg  [7:0]  regWrData = 8'h00;
  reg         regWr = 1'b0;
  reg         regRd = 1'b0;
  reg         txDataIn = 1'b0;
  reg         bpTick = 1'b0;
  reg         sigLoss = 1'b0;
  reg  [2:0]  tk = 3'h0;
  wire [7:0]  regRdData;
  wire        linePos, lineNeg, lineStrobe, recTick, mstTick, bufferInUse, irq;
  wire [1:0]  txClockSource;
  wire [15:0] markCnt, bpvCnt, strobeCnt;
  integer     fails = 0;
  integer     nTests = 0;
  integer     cyc = 0;
  reg  [15:0] v0;
  always #2 clk = ~clk;
  txlb_backend txlb_backend_i (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txDataIn(txDataIn), .bpTick(bpTick),
    .recTick(recTick), .mstTick(mstTick), .receiveSignalLoss(sigLoss), .linePos(linePos), .lineNeg(lineNeg),
    .lineStrobe(lineStrobe), .txClockSource(txClockSource), .bufferInUse(bufferInUse), .bufferSlip(),
    .irq(irq));
  txlb_line_partner txlb_line_partner_i (.clk(clk), .rst(rst), .linePos(linePos), .lineNeg(lineNeg),
    .lineStrobe(lineStrobe), .recTick(recTick), .mstTick(mstTick), .markCnt(markCnt), .bpvCnt(bpvCnt),
    .strobeCnt(strobeCnt));
  // ****************************************************************
  // Backplane tick, timeout and tasks
  // ****************************************************************
  always @(posedge clk)
  begin
    tk     <= tk + 3'h1;
    bpTick <= (tk == 3'h0);
    cyc    <= cyc + 1;
    if (cyc == 12000)
    begin
      fails = fails + 1;
      finish_test;
    end
  end
  task finish_test;
    begin
      if (fails == 0 && nTests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [8*8:1] nm, input [15:0] seen, input [15:0] exp);
    begin
      nTests = nTests + 1;
      if (seen !== exp)
      begin
        fails = fails + 1;
        $display("ERROR %0s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [9:0] a, input [7:0] d);
    begin
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [9:0] a, input [7:0] e);
    begin
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      chk("regRd", {8'h00, regRdData}, {8'h00, e});
      @(posedge clk);
    end
  endtask
  task rw(input [9:0] a, input [7:0] d);
    begin
      wr(a, d);
      rd(a, d);
      wr(a, 8'h00);
    end
  endtask
  task ck(input [3:0] m, input t, input b, input [1:0] s);
    begin
      wr(`TXLB_ADDR_MODE, {4'h0, m});
      wr(`TXLB_ADDR_TIMING, {7'h00, t});
      repeat (4) @(posedge clk);
      chk("bufInUse", {15'h0000, bufferInUse}, {15'h0000, b});
      if (s != 2'h3)
        chk("clkSrc", {14'h0000, txClockSource}, {14'h0000, s});
    end
  endtask
  task lw(input [15:0] n, input [15:0] m, input [15:0] v);
    reg [15:0] m0, b0, s0;
    begin
      repeat (256) @(posedge clk);
      m0 = markCnt;
      b0 = bpvCnt;
      s0 = strobeCnt;
      repeat (8 * n) @(posedge clk);
      chk("strobes", strobeCnt - s0, n);
      chk("marks", markCnt - m0, m);
      chk("bpv", bpvCnt - b0, v);
    end
  endtask
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rw(`TXLB_ADDR_JA_CFG, 8'h2D);
    rw(`TXLB_ADDR_TX_CFG0, 8'h01);
    rw(`TXLB_ADDR_MAINT1, 8'h01);
    rw(`TXLB_ADDR_IRQ_EN1, 8'h01);
    rw(`TXLB_ADDR_TIMING, 8'h01);
    wr(10'h3FF, 8'hFF);
    rd(10'h3FF, 8'h00);
    ck(4'h0, 1'b1, 1'b1, `TXLB_SRC_MASTER);
    ck(4'h1, 1'b1, 1'b1, `TXLB_SRC_MASTER);
    ck(4'h4, 1'b1, 1'b1, `TXLB_SRC_MASTER);
    ck(4'h4, 1'b0, 1'b0, `TXLB_SRC_BACKPLANE);
    ck(4'h8, 1'b0, 1'b1, `TXLB_SRC_MASTER);
    ck(4'h2, 1'b1, 1'b0, `TXLB_SRC_MASTER);
    ck(4'h2, 1'b0, 1'b0, `TXLB_SRC_LINE);
    ck(4'h0, 1'b0, 1'b0, `TXLB_SRC_BACKPLANE);
    wr(`TXLB_ADDR_FGEN1, 8'h01);
    lw(16'd8, 16'd8, 16'd0);
    txDataIn <= 1'b1;
    wr(`TXLB_ADDR_FGEN1, 8'h03);
    lw(16'd8, 16'd0, 16'd0);
    wr(`TXLB_ADDR_FGEN1, 8'h02);
    lw(16'd8, 16'd0, 16'd0);
    wr(`TXLB_ADDR_FGEN1, 8'h00);
    lw(16'd8, 16'd8, 16'd0);
    v0 = bpvCnt;
    wr(`TXLB_ADDR_MAINT2, 8'h01);
    repeat (96) @(posedge clk);
    chk("bpvIns", bpvCnt - v0, 16'd1);
    wr(`TXLB_ADDR_MAINT2, 8'h01);
    repeat (96) @(posedge clk);
    chk("bpvHold", bpvCnt - v0, 16'd1);
    txDataIn <= 1'b0;
    wr(`TXLB_ADDR_MAINT1, 8'h01);
    sigLoss <= 1'b1;
    lw(16'd8, 16'd8, 16'd0);
    sigLoss <= 1'b0;
    lw(16'd8, 16'd0, 16'd0);
    wr(`TXLB_ADDR_TX_CFG0, 8'h01);
    lw(16'd16, 16'd8, 16'd4);
    wr(`TXLB_ADDR_MODE, 8'h01);
    lw(16'd16, 16'd8, 16'd4);
    wr(`TXLB_ADDR_TX_CFG0, 8'h00);
    lw(16'd8, 16'd0, 16'd0);
    wr(`TXLB_ADDR_IRQ_EN1, 8'h01);
    wr(`TXLB_ADDR_JA_CFG, 8'h01);
    repeat (400) @(posedge clk);
    chk("irq", {15'h0000, irq}, 16'h0001);
    rd(`TXLB_ADDR_IRQ_ST1, 8'h01);
    wr(`TXLB_ADDR_JA_CFG, 8'h00);
    wr(`TXLB_ADDR_IRQ_ST1, 8'h01);
    rd(`TXLB_ADDR_IRQ_ST1, 8'h00);
    chk("irqOff", {15'h0000, irq}, 16'h0000);
    finish_test;
  end
endmodule // txlb_backend_tb
